// File: omsup_pkg.sv
// Shared constants and types for the operating mode supervisor
package omsup_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned CYC_PER_MS   = CLK_HZ / 1_000;
  localparam int unsigned CYC_PER_US   = CLK_HZ / 1_000_000;
  localparam int unsigned T_IN_MS      = 250;
  localparam int unsigned T_WDTO_MS    = 310;
  localparam int unsigned T_START_US   = 50;
  localparam int unsigned IN_TIMEOUT_CYC = T_IN_MS * CYC_PER_MS;
  localparam int unsigned WDTO_CYC       = T_WDTO_MS * CYC_PER_MS;
  localparam int unsigned START_CYC      = T_START_US * CYC_PER_US;
  localparam int unsigned CNT_W          = 24;
  localparam int unsigned START_W        = 11;

  // Serial word layout
  localparam int unsigned WORD_BITS  = 16;
  localparam int unsigned BITCNT_W   = 5;

  // Number of switch channels
  localparam int unsigned NCH = 2;

  typedef enum logic [1:0] {
    OMSUP_SLEEP,
    OMSUP_NORMAL,
    OMSUP_FAILSAFE,
    OMSUP_FAULT
  } omsup_mode_t;

  // Fault sources, also used as the sticky fault bit image
  typedef struct packed {
    logic [1:0] over_current;
    logic [1:0] thermal_trip;
    logic [1:0] short_to_ground;
    logic [1:0] open_load_on;
    logic [1:0] open_load_off;
    logic [1:0] short_to_supply;
    logic [1:0] clock_fail;
    logic       supply_low;
    logic       supply_high;
  } omsup_fault_t;

  // Global configuration bits
  typedef struct packed {
    logic watchdog_off;
    logic vdd_fail_en;
    logic overvoltage_select;
    logic open_load_on_en;
    logic open_load_off_en;
    logic short_to_supply_en;
    logic clock_fail_en;
  } omsup_cfg_t;

  localparam omsup_cfg_t CFG_RESET = 7'h11;
  localparam logic [15:0] FAULT_NONE = 16'h0000;

endpackage

// File: omsup_in_timer.sv
// Direct input activity timer producing the input-active level
`timescale 1ns/1ps
module omsup_in_timer #(
  parameter int unsigned TIMEOUT = omsup_pkg::IN_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  // Synchronised direct input
  input  wire logic level_i,
  // Activity state
  output logic      active_o
);
  import omsup_pkg::*;

  logic             level_q;
  logic [CNT_W-1:0] idle_cnt;
  wire              rise_w    = level_i & ~level_q;
  wire              expired_w = (idle_cnt == CNT_W'(TIMEOUT - 1));

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level_i;
    end
  end

  // High level holds the count at zero; a long low drops activity
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      idle_cnt <= '0;
    end else if (level_i || !active_o) begin
      idle_cnt <= '0;
    end else if (!expired_w) begin
      idle_cnt <= idle_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      active_o <= 1'b0;
    end else if (rise_w) begin
      active_o <= 1'b1;
    end else if (expired_w && !level_i) begin
      active_o <= 1'b0;
    end
  end

endmodule // omsup_in_timer

// File: omsup_top.sv
// Operating mode supervisor: wake-up, watchdog, fail-safe and fault modes
//
// Overview of operation
// - Rising wake pin or rising direct input moves sleep to normal.
// - Input-active drops after no direct input activity for the input timeout.
// - Both inputs idle and wake pin low gives sleep; wake is their OR.
// - Fail-safe on supply loss if enabled, or watchdog timeout unless off.
// - Fault is overcurrent, thermal, short, undervoltage or selected overvoltage.
// - Wake-up low means sleep with all channels off.
// - Normal when awake without fail-safe or fault; watchdog runs conditionally.
// - Fail-safe alone gives direct input control; any fault gives fault mode.
// - Watchdog starts on rising wake pin with supply; checks each word's first bit.
// - Timeout from internal clock; no toggle within it means communication lost.
// - Fail-safe drives its output low and hands channels to direct inputs.
// - Fail-safe entry delatches, resets registers, blocks register access.
// - Exit fail-safe: word with toggle bit one, then another within timeout.
// - Back to normal releases fail-safe output, resets all but latched bits.
// - Fault status output low in real time; matching sticky bit set.
// - Fault bit sticks; read clears it only if cause gone and unlatched.
// - Faults turn off their channel except open-load, clock, short-to-supply.
// - Reset disables short-to-supply and open-load; enables clock fail, overvoltage.
// - Fault during fail-safe keeps registers reset, blocked, direct control.
// - Fault cleared in fail-safe returns to fail-safe without delatching.
// - Wake pin low: channels follow direct inputs with protections active.
// - Power-up in sleep with channels and serial port off, defaults kept.
// - Wake-up resets registers, enters normal; full function after start delay.
`timescale 1ns/1ps
module omsup_top #(
  parameter int unsigned IN_TIMEOUT = omsup_pkg::IN_TIMEOUT_CYC,
  parameter int unsigned WDTO       = omsup_pkg::WDTO_CYC
) (
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_i,
  // Pins from the host
  input  wire logic                   wake_reset_n_i,
  input  wire logic [1:0]             direct_in_i,
  input  wire logic                   spi_sclk_i,
  input  wire logic                   spi_cs_n_i,
  input  wire logic                   spi_mosi_i,
  // Supply and analog fault monitors
  input  wire logic                   vdd_ok_i,
  input  wire omsup_pkg::omsup_fault_t fault_src_i,
  // Register side, same clock
  input  wire logic [1:0]             spi_drive_i,
  input  wire logic [1:0]             latched_i,
  input  wire logic                   cfg_wr_i,
  input  wire omsup_pkg::omsup_cfg_t  cfg_data_i,
  input  wire logic [1:0]             channel_fault_read_i,
  input  wire logic                   global_status_read_i,
  // Mode and status
  output omsup_pkg::omsup_mode_t      mode_o,
  output logic                        normal_flag_o,
  output logic                        failsafe_out_n_o,
  output logic                        fault_status_n_o,
  output logic                        ready_o,
  output logic                        watchdog_run_o,
  // Channel control
  output logic [1:0]                  channel_on_o,
  output logic                        direct_ctrl_o,
  // Register effects
  output logic                        spi_access_o,
  output logic                        reg_reset_o,
  output logic                        keep_latched_o,
  output logic                        delatch_o,
  output omsup_pkg::omsup_cfg_t       global_config_reg_o,
  output omsup_pkg::omsup_fault_t     fault_bits_o
);
  import omsup_pkg::*;

  // Two-stage synchronisers for every pin
  localparam int unsigned NSYNC = 7 + $bits(omsup_fault_t);
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  wire  [NSYNC-1:0] pins_w = {wake_reset_n_i, direct_in_i, spi_sclk_i, spi_cs_n_i,
                              spi_mosi_i, vdd_ok_i, fault_src_i};

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1 <= NSYNC'(1) << (NSYNC - 5);
      sync2 <= NSYNC'(1) << (NSYNC - 5);
    end else begin
      sync1 <= pins_w;
      sync2 <= sync1;
    end
  end

  wire              rst_pin_w = sync2[NSYNC-1];
  wire [1:0]        din_w     = sync2[NSYNC-2:NSYNC-3];
  wire              sclk_w    = sync2[NSYNC-4];
  wire              cs_n_w    = sync2[NSYNC-5];
  wire              mosi_w    = sync2[NSYNC-6];
  wire              vdd_w     = sync2[NSYNC-7];
  omsup_fault_t     fsrc_w;
  assign fsrc_w = sync2[$bits(omsup_fault_t)-1:0];

  // Input activity timers
  logic [1:0] in_active;
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_in
      omsup_in_timer #(.TIMEOUT(IN_TIMEOUT)) u_timer (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .level_i   (din_w[gi]),
        .active_o  (in_active[gi])
      );
    end
  endgenerate

  // Serial frame sampler; data sampled on the rising clock edge
  logic                sclk_q;
  logic                cs_q;
  logic                rst_pin_q;
  logic [BITCNT_W-1:0] bit_cnt;
  logic                first_bit;
  logic                prev_bit;
  wire sclk_rise_w = sclk_w & ~sclk_q;
  wire cs_end_w    = cs_n_w & ~cs_q;
  wire word_w      = cs_end_w && (bit_cnt == BITCNT_W'(WORD_BITS));
  wire rst_rise_w  = rst_pin_w & ~rst_pin_q;
  wire toggle_w    = word_w && (first_bit != prev_bit);

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_q    <= 1'b0;
      cs_q      <= 1'b1;
      rst_pin_q <= 1'b0;
      bit_cnt   <= '0;
      first_bit <= 1'b0;
      prev_bit  <= 1'b0;
    end else begin
      sclk_q    <= sclk_w;
      cs_q      <= cs_n_w;
      rst_pin_q <= rst_pin_w;
      if (cs_n_w) begin
        bit_cnt <= '0;
      end else if (sclk_rise_w && bit_cnt != BITCNT_W'(31)) begin
        bit_cnt <= bit_cnt + BITCNT_W'(1);
      end
      if (!cs_n_w && sclk_rise_w && bit_cnt == '0) begin
        first_bit <= mosi_w;
      end
      if (word_w) begin
        prev_bit <= first_bit;
      end
    end
  end

  // Mode decode
  omsup_mode_t  mode_q;
  omsup_cfg_t   cfg;
  omsup_fault_t sticky;
  omsup_fault_t act_w;
  logic         wd_run;
  logic         wd_lost;
  logic         vdd_seen;
  logic         rec_armed;
  logic [CNT_W-1:0] wd_cnt;
  logic         fs_q;
  logic         flt_q;

  assign act_w.over_current    = fsrc_w.over_current;
  assign act_w.thermal_trip    = fsrc_w.thermal_trip;
  assign act_w.short_to_ground = fsrc_w.short_to_ground;
  assign act_w.open_load_on    = fsrc_w.open_load_on & {2{cfg.open_load_on_en}};
  assign act_w.open_load_off   = fsrc_w.open_load_off & {2{cfg.open_load_off_en}};
  assign act_w.short_to_supply = fsrc_w.short_to_supply & {2{cfg.short_to_supply_en}};
  assign act_w.clock_fail      = fsrc_w.clock_fail & {2{cfg.clock_fail_en}};
  assign act_w.supply_low      = fsrc_w.supply_low;
  assign act_w.supply_high     = fsrc_w.supply_high & cfg.overvoltage_select;

  // wake-up is pin or either input active
  wire wake_w = rst_pin_w | (|in_active);
  wire vdd_lost_w = vdd_seen & ~vdd_w & cfg.vdd_fail_en;
  wire fs_w       = vdd_lost_w | (wd_lost & ~cfg.watchdog_off);
  wire flt_w = (|act_w.over_current) | (|act_w.thermal_trip) | (|act_w.short_to_ground)
             | act_w.supply_low | act_w.supply_high;

  omsup_mode_t next_mode;
  assign next_mode = !wake_w ? OMSUP_SLEEP :
                     flt_w   ? OMSUP_FAULT :
                     fs_w    ? OMSUP_FAILSAFE : OMSUP_NORMAL;

  wire wake_evt_w = (mode_q == OMSUP_SLEEP) && (next_mode != OMSUP_SLEEP);
  // fail-safe entry from normal or fault
  wire fs_enter_w = wake_w && fs_w && !fs_q;
  // return from fail-safe keeps latched bits
  wire fs_leave_w = wake_w && !fs_w && fs_q;
  wire regrst_w   = wake_evt_w | fs_enter_w | fs_leave_w;

  wire wd_count_w = wd_run && vdd_w && !cfg.watchdog_off && rst_pin_w && !wd_lost;
  wire wd_exp_w   = (wd_cnt == CNT_W'(WDTO - 1));

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wd_run <= 1'b0;
    end else if (next_mode == OMSUP_SLEEP) begin
      wd_run <= 1'b0;
    end else if (rst_rise_w && vdd_w) begin
      wd_run <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wd_cnt <= '0;
    end else if (toggle_w | rst_rise_w | (rec_armed & word_w) | ~(wd_count_w | rec_armed)) begin
      wd_cnt <= '0;
    end else if (!wd_exp_w) begin
      wd_cnt <= wd_cnt + CNT_W'(1);
    end
  end

  // Lost flag; the recovery sequence clears it
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wd_lost   <= 1'b0;
      rec_armed <= 1'b0;
    end else if (next_mode == OMSUP_SLEEP) begin
      wd_lost   <= 1'b0;
      rec_armed <= 1'b0;
    end else if (wd_count_w && wd_exp_w && !toggle_w) begin
      wd_lost <= 1'b1;
    end else if (wd_lost && rec_armed && word_w) begin
      // second word inside the window ends fail-safe
      wd_lost   <= 1'b0;
      rec_armed <= 1'b0;
    end else if (rec_armed && wd_exp_w) begin
      rec_armed <= 1'b0;
    end else if (wd_lost && word_w && first_bit) begin
      rec_armed <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      vdd_seen <= 1'b0;
      fs_q     <= 1'b0;
      flt_q    <= 1'b0;
      mode_q   <= OMSUP_SLEEP;
    end else begin
      vdd_seen <= (vdd_seen | vdd_w) & (next_mode != OMSUP_SLEEP);
      fs_q     <= wake_w & fs_w;
      flt_q    <= wake_w & flt_w;
      mode_q   <= next_mode;
    end
  end

  // Configuration: default on reset, register reset or while asleep
  wire access_w = (next_mode == OMSUP_NORMAL) || (next_mode == OMSUP_FAULT && !fs_w);
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg <= CFG_RESET;
    end else if (regrst_w || next_mode == OMSUP_SLEEP) begin
      cfg <= CFG_RESET;
    end else if (cfg_wr_i && spi_access_o) begin
      cfg <= cfg_data_i;
    end
  end

  // Sticky fault bits
  function automatic omsup_fault_t chan_mask(input int ch);
    omsup_fault_t m;
    m = FAULT_NONE;
    m.over_current[ch]    = 1'b1;
    m.thermal_trip[ch]    = 1'b1;
    m.short_to_ground[ch] = 1'b1;
    m.open_load_on[ch]    = 1'b1;
    m.open_load_off[ch]   = 1'b1;
    m.short_to_supply[ch] = 1'b1;
    m.clock_fail[ch]      = 1'b1;
    return m;
  endfunction

  function automatic omsup_fault_t latch_mask(input int ch);
    omsup_fault_t m;
    m = FAULT_NONE;
    m.over_current[ch]    = 1'b1;
    m.thermal_trip[ch]    = 1'b1;
    m.short_to_ground[ch] = 1'b1;
    return m;
  endfunction

  omsup_fault_t glob_mask_w;
  assign glob_mask_w = '{supply_low: 1'b1, supply_high: 1'b1, default: '0};
  wire [15:0] read_mask_w = ({16{channel_fault_read_i[0]}} & chan_mask(0))
                          | ({16{channel_fault_read_i[1]}} & chan_mask(1))
                          | ({16{global_status_read_i}} & glob_mask_w);
  wire [15:0] keep_w = ({16{latched_i[0]}} & latch_mask(0))
                     | ({16{latched_i[1]}} & latch_mask(1));
  // read clears only absent, unlatched causes
  wire [15:0] clr_w  = read_mask_w & ~act_w & ~keep_w;
  // register reset keeps latched bits only on return to normal
  wire [15:0] hold_w = !regrst_w ? 16'hFFFF : (fs_leave_w ? keep_w : FAULT_NONE);

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sticky <= FAULT_NONE;
    end else begin
      sticky <= (sticky & ~clr_w & hold_w) | act_w;
    end
  end

  // Channel gating
  wire direct_w = !rst_pin_w || (next_mode == OMSUP_FAILSAFE) || fs_w;
  wire uvov_w   = act_w.supply_low | act_w.supply_high;
  logic [1:0] ch_next;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      // affected channel off, supply faults take both
      wire off_w = act_w.over_current[gi] | act_w.thermal_trip[gi]
                 | act_w.short_to_ground[gi] | uvov_w;
      // serial drive only outside direct control; direct inputs always count
      wire req_w = direct_w ? din_w[gi] : (din_w[gi] | spi_drive_i[gi]);
      assign ch_next[gi] = (next_mode != OMSUP_SLEEP) && !off_w && req_w;
    end
  endgenerate

  // Start-up delay after wake-up
  logic [START_W-1:0] start_cnt;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      start_cnt <= '0;
    end else if (wake_evt_w || next_mode == OMSUP_SLEEP) begin
      start_cnt <= '0;
    end else if (start_cnt != START_W'(START_CYC)) begin
      start_cnt <= start_cnt + START_W'(1);
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_o              <= OMSUP_SLEEP;
      normal_flag_o       <= 1'b0;
      failsafe_out_n_o    <= 1'b1;
      fault_status_n_o    <= 1'b1;
      ready_o             <= 1'b0;
      watchdog_run_o      <= 1'b0;
      channel_on_o        <= 2'h0;
      direct_ctrl_o       <= 1'b1;
      spi_access_o        <= 1'b0;
      reg_reset_o         <= 1'b0;
      keep_latched_o      <= 1'b0;
      delatch_o           <= 1'b0;
      global_config_reg_o <= CFG_RESET;
      fault_bits_o        <= FAULT_NONE;
    end else begin
      mode_o              <= next_mode;
      normal_flag_o       <= (next_mode == OMSUP_NORMAL);
      failsafe_out_n_o    <= !(wake_w && fs_w);
      fault_status_n_o    <= !(wake_w && (|act_w));
      // full function after the start delay
      ready_o             <= (next_mode != OMSUP_SLEEP) && !wake_evt_w
                             && (start_cnt == START_W'(START_CYC));
      watchdog_run_o      <= wd_count_w;
      channel_on_o        <= ch_next;
      direct_ctrl_o       <= direct_w;
      spi_access_o        <= access_w && !rec_armed && !regrst_w;
      reg_reset_o         <= regrst_w;
      keep_latched_o      <= fs_leave_w;
      // delatch only on a fresh fail-safe entry
      delatch_o           <= fs_enter_w;
      global_config_reg_o <= cfg;
      fault_bits_o        <= sticky;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_lost;
    wd_count_w && wd_exp_w && !toggle_w;
  endsequence
  sequence s_failsafe_pin;
    ##1 wd_lost ##1 (!failsafe_out_n_o || !wake_w || cfg.watchdog_off);
  endsequence

  sleep_channels_off_a: assert property (
    mode_o == OMSUP_SLEEP |-> channel_on_o == 2'h0)
    else $error("channel on while asleep");
  failsafe_pin_low_a: assert property (
    mode_o == OMSUP_FAILSAFE |-> !failsafe_out_n_o && direct_ctrl_o && !spi_access_o)
    else $error("fail-safe outputs wrong");
  watchdog_loss_a: assert property (
    s_lost |-> s_failsafe_pin)
    else $error("watchdog loss not reported");
  failsafe_entry_a: assert property (
    fs_enter_w |=> delatch_o && reg_reset_o && !keep_latched_o)
    else $error("fail-safe entry effects missing");
  failsafe_leave_a: assert property (
    fs_leave_w |=> reg_reset_o && keep_latched_o && failsafe_out_n_o)
    else $error("return to normal effects missing");
  fault_mode_pin_a: assert property (
    mode_o == OMSUP_FAULT |-> !fault_status_n_o)
    else $error("fault mode without fault pin");
  fault_bit_sticky_a: assert property (
    (read_mask_w == FAULT_NONE) && !regrst_w |=>
      ((sticky & $past(sticky)) == $past(sticky)))
    else $error("sticky fault bit lost without read");
  wake_reset_regs_a: assert property (
    wake_evt_w |=> reg_reset_o && !ready_o ##1 !ready_o)
    else $error("wake-up without register reset");
  fault_in_fs_a: assert property (
    (mode_o == OMSUP_FAULT) && !failsafe_out_n_o |-> !spi_access_o && direct_ctrl_o)
    else $error("access open in fault fail-safe");

endmodule // omsup_top

// File: omsup_host_model.sv
// Host model: sends serial words to the supervisor
`timescale 1ns/1ps
module omsup_host_model (
  // Clock and request
  input  wire logic        sys_clk_i,
  input  wire logic        start_i,
  input  wire logic [15:0] word_i,
  // Serial pins and state
  output logic             sclk_o,
  output logic             cs_n_o,
  output logic             mosi_o,
  output logic             busy_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    busy_o = 1'b0;
  end
  always @(posedge sys_clk_i) begin
    if (start_i && !busy_o) begin
      busy_o <= 1'b1;
      cs_n_o <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        mosi_o <= word_i[15-i];
        repeat (4) @(posedge sys_clk_i);
        sclk_o <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        sclk_o <= 1'b0;
      end
      repeat (4) @(posedge sys_clk_i);
      cs_n_o <= 1'b1;
      // Released line shows no stale data
      mosi_o <= ~mosi_o;
      busy_o <= 1'b0;
    end
  end
endmodule // omsup_host_model

// File: testbench.sv
// Self-checking bench for the operating mode supervisor
`timescale 1ns/1ps
module testbench;
  import omsup_pkg::*;
  localparam int unsigned IN_TO = 200;
  localparam int unsigned WD_TO = 300;
  logic         sys_clk = 1'b0;
  logic         reset   = 1'b1;
  logic         wake_n  = 1'b0;
  logic [1:0]   din     = 2'h0;
  logic         vdd_ok  = 1'b0;
  omsup_fault_t fsrc    = '0;
  logic         cfg_wr  = 1'b0;
  omsup_cfg_t   cfg_d   = CFG_RESET;
  logic [1:0]   ch_rd   = 2'h0;
  logic         start   = 1'b0;
  logic [15:0]  word    = 16'h0000;
  logic         sclk, cs_n, mosi, busy;
  omsup_mode_t  mode;
  logic         nflag, fs_n, flt_n, rdy, wd_run, dctl, acc, rr, kl, dl;
  logic [1:0]   ch_on;
  omsup_cfg_t   gcfg;
  omsup_fault_t fbits;
  int           n_errors = 0;
  int           n_tests  = 0;

  always #25 sys_clk = ~sys_clk;

  omsup_host_model host_u (.sys_clk_i(sys_clk), .start_i(start), .word_i(word),
    .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .busy_o(busy));

  omsup_top #(.IN_TIMEOUT(IN_TO), .WDTO(WD_TO)) dut_u (
    .sys_clk_i(sys_clk), .reset_i(reset), .wake_reset_n_i(wake_n), .direct_in_i(din),
    .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .vdd_ok_i(vdd_ok),
    .fault_src_i(fsrc), .spi_drive_i(2'h0), .latched_i(2'h0), .cfg_wr_i(cfg_wr),
    .cfg_data_i(cfg_d), .channel_fault_read_i(ch_rd), .global_status_read_i(1'b0),
    .mode_o(mode), .normal_flag_o(nflag), .failsafe_out_n_o(fs_n),
    .fault_status_n_o(flt_n), .ready_o(rdy), .watchdog_run_o(wd_run),
    .channel_on_o(ch_on), .direct_ctrl_o(dctl), .spi_access_o(acc),
    .reg_reset_o(rr), .keep_latched_o(kl), .delatch_o(dl),
    .global_config_reg_o(gcfg), .fault_bits_o(fbits));

  task automatic close_out;
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Pulse the request for one cycle, then wait until the model is idle
  task automatic send(input logic [15:0] w);
    word <= w;
    start <= 1'b1;
    cyc(1);
    start <= 1'b0;
    cyc(2);
    for (int i = 0; i < 400 && busy; i++)
      cyc(1);
    cyc(6);
  endtask

  task automatic wait_mode(input omsup_mode_t m, input int lim);
    for (int i = 0; i < lim && mode !== m; i++)
      cyc(1);
    chk(mode, m);
  endtask

  initial begin
    cyc(12);
    reset <= 1'b0;
    cyc(2);
    chk(mode, OMSUP_SLEEP);
    chk({fs_n, flt_n, ch_on, acc}, 16'h0018);
    chk(gcfg, 16'h0011);
    din <= 2'h1;
    wait_mode(OMSUP_NORMAL, 10);
    cyc(2);
    chk(ch_on, 16'h0001);
    din <= 2'h0;
    cyc(IN_TO - 50);
    chk(mode, OMSUP_NORMAL);
    wait_mode(OMSUP_SLEEP, 100);
    fsrc.supply_low <= 1'b1;
    cyc(6);
    chk({mode, ch_on}, 16'h0000);
    fsrc <= '0;
    vdd_ok <= 1'b1;
    wake_n <= 1'b1;
    wait_mode(OMSUP_NORMAL, 10);
    cyc(3);
    chk({wd_run, rdy}, 16'h0002);
    chk(fbits, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      send(i[0] ? 16'h0000 : 16'h8000);
      chk(mode, OMSUP_NORMAL);
    end
    cyc(WD_TO - 60);
    chk(mode, OMSUP_NORMAL);
    wait_mode(OMSUP_FAILSAFE, 100);
    din <= 2'h3;
    cyc(6);
    chk({fs_n, dctl, acc, ch_on}, 16'h000B);
    fsrc.over_current <= 2'h2;
    wait_mode(OMSUP_FAULT, 10);
    cyc(2);
    chk({flt_n, ch_on, acc}, 16'h0002);
    fsrc <= '0;
    wait_mode(OMSUP_FAILSAFE, 10);
    cyc(2);
    chk({flt_n, fs_n, fbits.over_current}, 16'h000A);
    ch_rd <= 2'h2;
    cyc(1);
    ch_rd <= 2'h0;
    // Long enough for the start-up delay to have run out
    cyc(300);
    chk({rdy, fbits.over_current}, 16'h0004);
    fsrc.supply_high <= 1'b1;
    wait_mode(OMSUP_FAULT, 10);
    fsrc <= '0;
    wait_mode(OMSUP_FAILSAFE, 10);
    send(16'h0000);
    chk(mode, OMSUP_FAILSAFE);
    send(16'h8000);
    chk({mode, acc}, {OMSUP_FAILSAFE, 1'b0});
    send(16'h0000);
    wait_mode(OMSUP_NORMAL, 10);
    cyc(2);
    chk({fs_n, acc}, 16'h0003);
    cfg_d <= CFG_RESET | 7'h40;
    cfg_wr <= 1'b1;
    cyc(1);
    cfg_wr <= 1'b0;
    cyc(3);
    chk(gcfg, 16'h0051);
    cyc(WD_TO + 50);
    chk(mode, OMSUP_NORMAL);
    close_out();
  end

  initial begin
    cyc(6000);
    n_errors++;
    close_out();
  end
endmodule // testbench
